// file: logic/drfam_defs.vh
// constants for the dram refresh and access mode controller
`ifndef DRFAM_DEFS_VH
`define DRFAM_DEFS_VH
`define DRFAM_ADDR_CTRL        12'h000
`define DRFAM_ADDR_STATUS      12'h004
`define DRFAM_ADDR_ROWCOL      12'h008
`define DRFAM_CTRL_RST         32'h0000_0000
`define DRFAM_CTRL_RAHS_BIT    0
`define DRFAM_CTRL_BANK_LSB    1
`define DRFAM_CTRL_BANK_MSB    2
`define DRFAM_REF_MAX          9'h1ff
`define DRFAM_MODE_EXT_REF     2'h0
`define DRFAM_MODE_AUTO_REF    2'h1
`define DRFAM_MODE_EXT_ACC     2'h2
`define DRFAM_MODE_AUTO_ACC    2'h3
`define DRFAM_RELEASE_NS       20
`define DRFAM_RELEASE_CYC      4'h5
`define DRFAM_CAS_SETUP_NS     8
`define DRFAM_CAS_SETUP_CYC    4'h2
`define DRFAM_RAH_SHORT_NS     12
`define DRFAM_RAH_LONG_NS      20
`define DRFAM_RAH_SHORT_CYC    4'h3
`define DRFAM_RAH_LONG_CYC     4'h5
`endif

// file: logic/drfam_ctrl.v
// dram controller: refresh counter, forced refresh, external and automatic access
//
// Behaviour
// (RULE1) two mode pins select one of four modes
// (RULE2) counter advances when row strobe input rises
// (RULE3) counter counts to 511 then wraps
// (RULE4) column strobe stays inactive during refresh
// (RULE5) forced mode: select and column pins become clocks
// (RULE6) period clock high on entry: external refresh
// (RULE7) external low on request pin clears counter
// (RULE8) request low on period clock fall without refresh
// (RULE9) outside reset driver must be open collector
// (RULE10) system finishes access, then drops high mode bit
// (RULE11) forced refresh puts counter on address outputs
// (RULE12) strobes low second sequence fall, two more
// (RULE13) request released when refresh strobes fall
// (RULE14) high mode bit rising ends refresh after delay
// (RULE15) system keeps minimum strobe low and precharge
// (RULE16) system stalls processor during forced refresh
// (RULE17) external access: outputs follow their inputs
// (RULE18) select high row address, low column address
// (RULE19) system holds select through row address hold
// (RULE20) system toggles column input for page accesses
// (RULE21) column strobe high while select high
// (RULE22) column input low at select fall: auto strobe
// (RULE23) external access pairs with external refresh only
// (RULE24) automatic access derives all strobes from row input
// (RULE25) automatic mode: select and column pins unused; the code still uses the select pin as period clock for hidden refresh
// (RULE26) system starts automatic access with row input low
// (RULE27) one refresh per period clock, flag tracks it
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "drfam_defs.vh"
module drfam_ctrl
(
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // system side mode and strobe inputs (strobes, write and chip select active low; mode bits and addr_strobe active high)
   input  wire        mode_bit_high,
   input  wire        mode_bit_low,
   input  wire        row_strobe_input_n,
   input  wire        col_strobe_input_n,
   input  wire        row_col_select,
   input  wire        write_input_n,
   input  wire        chip_select_n,
   input  wire [8:0]  row_addr_in,
   input  wire [8:0]  col_addr_in,
   input  wire        addr_strobe,
   // refresh request / reset open-drain pin
   input  wire        refresh_req_reset_pin_in,
   output wire        refresh_req_reset_pin_out,
   output wire        refresh_req_reset_pin_oe,
   // dram side
   output reg  [3:0]  row_strobe_n,
   output reg         col_strobe_n,
   output reg         write_enable_n,
   output reg  [8:0]  dram_addr
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_WAIT  = 3'h1;
   localparam [2:0] ST_LOW   = 3'h2;
   localparam [2:0] ST_REL   = 3'h3;
   localparam [2:0] ST_DONE  = 3'h4;
   localparam [3:0] REL_CYC  = `DRFAM_RELEASE_CYC;
   localparam [3:0] CASU_CYC = `DRFAM_CAS_SETUP_CYC;
   localparam [3:0] RAHS_CYC = `DRFAM_RAH_SHORT_CYC;
   localparam [3:0] RAHL_CYC = `DRFAM_RAH_LONG_CYC;

   reg  [31:0] ctrl;
   reg  [8:0]  ref_count;
   reg  [8:0]  row_latch;
   reg  [8:0]  col_latch;
   reg  [2:0]  fr_state;
   reg  [1:0]  fall_cnt;
   reg  [3:0]  rel_cnt;
   reg         refreshed;
   reg         req_active;
   reg         fr_bypass;
   reg         prev_rowin_n;
   reg         prev_seqclk;
   reg         prev_perclk;
   reg         prev_mode_auto_ref;
   reg         prev_sel;
   reg  [3:0]  cas_cnt;
   reg         auto_cas;
   reg  [3:0]  acc_cnt;
   reg         acc_col;
   reg  [3:0]  next_row_strobe_n;
   reg         next_col_strobe_n;
   reg  [8:0]  next_dram_addr;

   wire [1:0] mode = {mode_bit_high, mode_bit_low}; // RULE1
   wire mode_ext_ref  = (mode == `DRFAM_MODE_EXT_REF);
   wire mode_auto_ref = (mode == `DRFAM_MODE_AUTO_REF);
   wire mode_ext_acc  = (mode == `DRFAM_MODE_EXT_ACC);
   wire mode_auto_acc = (mode == `DRFAM_MODE_AUTO_ACC);
   // forced mode repurposes the select and column pins as clocks
   wire perclk = row_col_select;     // RULE5
   wire seqclk = col_strobe_input_n; // RULE5
   wire seq_fall = prev_seqclk & ~seqclk;
   wire per_fall = prev_perclk & ~perclk;
   wire per_rise = ~prev_perclk & perclk;
   wire rowin_rise = ~prev_rowin_n & row_strobe_input_n;
   wire ext_clear = ~refresh_req_reset_pin_in & ~req_active;
   // external-style refresh: mode 0, bypassed mode 1, hidden refresh in mode 3
   wire hidden_ok = mode_auto_acc & chip_select_n & perclk & ~refreshed;
   wire ext_refresh = mode_ext_ref | (mode_auto_ref & fr_bypass) | hidden_ok;
   wire forced_active = mode_auto_ref & ~fr_bypass;
   wire next_fr_done = mode_bit_high | (seq_fall & fall_cnt == 2'h1);
   wire [3:0] bank_en = 4'h1 << ctrl[`DRFAM_CTRL_BANK_MSB:`DRFAM_CTRL_BANK_LSB];
   wire [3:0] rah_cyc = ctrl[`DRFAM_CTRL_RAHS_BIT] ? RAHL_CYC : RAHS_CYC;
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd = psel & ~penable & ~pwrite;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   // open-drain request: drive low only while requesting
   assign refresh_req_reset_pin_out = 1'b0;
   assign refresh_req_reset_pin_oe  = req_active;

   // apb registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl   <= `DRFAM_CTRL_RST;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         if (apb_wr && paddr == `DRFAM_ADDR_CTRL)
            ctrl <= {29'h0000_0000, pwdata[2:0]};
         if (apb_rd)
         begin
            case (paddr)
               `DRFAM_ADDR_CTRL:   prdata <= ctrl;
               `DRFAM_ADDR_STATUS: prdata <= {15'h0000, req_active, refreshed, fr_bypass,
                                              fr_state, mode, ref_count};
               `DRFAM_ADDR_ROWCOL: prdata <= {14'h0000, col_latch, row_latch};
               default:            prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // address registers load on each clock while the strobe is high
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         row_latch <= 9'h000;
         col_latch <= 9'h000;
      end
      else if (addr_strobe)
      begin
         row_latch <= row_addr_in;
         col_latch <= col_addr_in;
      end
   end

   // edge history
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_rowin_n       <= 1'b1;
         prev_seqclk        <= 1'b1;
         prev_perclk        <= 1'b0;
         prev_mode_auto_ref <= 1'b0;
         prev_sel           <= 1'b1;
      end
      else
      begin
         prev_rowin_n       <= row_strobe_input_n;
         prev_seqclk        <= seqclk;
         prev_perclk        <= perclk;
         prev_mode_auto_ref <= mode_auto_ref;
         prev_sel           <= row_col_select;
      end
   end

   // bypass latched on entry to forced mode when period clock is high
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fr_bypass <= 1'b0;
      else if (mode_auto_ref && !prev_mode_auto_ref)
         fr_bypass <= perclk; // RULE6
      else if (!mode_auto_ref)
         fr_bypass <= 1'b0;
   end

   // forced refresh sequencer on sequence clock falls
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fr_state <= ST_IDLE;
         fall_cnt <= 2'h0;
         rel_cnt  <= 4'h0;
      end
      else
      begin
         case (fr_state)
            ST_IDLE:
               if (forced_active)
               begin
                  fr_state <= ST_WAIT;
                  fall_cnt <= 2'h0;
               end
            ST_WAIT:
               if (!forced_active)
                  fr_state <= ST_IDLE;
               else if (seq_fall)
               begin
                  if (fall_cnt == 2'h1)
                  begin
                     fr_state <= ST_LOW; // RULE12
                     fall_cnt <= 2'h0;
                  end
                  else
                     fall_cnt <= fall_cnt + 2'h1;
               end
            ST_LOW:
               if (mode_bit_high)
               begin
                  fr_state <= ST_REL; // RULE14
                  rel_cnt  <= REL_CYC - 4'h1;
               end
               else if (seq_fall)
               begin
                  if (fall_cnt == 2'h1)
                     fr_state <= ST_DONE; // RULE12
                  else
                     fall_cnt <= fall_cnt + 2'h1;
               end
            ST_REL:
               if (rel_cnt == 4'h0)
                  fr_state <= ST_DONE; // RULE14
               else
                  rel_cnt <= rel_cnt - 4'h1;
            ST_DONE:
               if (!mode_auto_ref)
                  fr_state <= ST_IDLE;
            default:
               fr_state <= ST_IDLE;
         endcase
      end
   end

   // refresh counter, period flag and request
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_count  <= 9'h000;
         refreshed  <= 1'b0;
         req_active <= 1'b0;
      end
      else
      begin
         if (mode_auto_ref && ext_clear)
            ref_count <= 9'h000; // RULE7
         else if ((ext_refresh && rowin_rise) || (fr_state == ST_LOW && next_fr_done))
            ref_count <= (ref_count == `DRFAM_REF_MAX) ? 9'h000 : ref_count + 9'h001; // RULE2 RULE3
         // completion wins over the period-clock clear
         if ((ext_refresh && rowin_rise) || (fr_state == ST_LOW && next_fr_done))
            refreshed <= 1'b1; // RULE27
         else if (per_rise)
            refreshed <= 1'b0; // RULE27
         if (per_fall && !refreshed && !(ext_refresh && rowin_rise))
            req_active <= 1'b1; // RULE8
         else if ((fr_state == ST_WAIT && seq_fall && fall_cnt == 2'h1) || mode_ext_ref)
            req_active <= 1'b0; // RULE13
      end
   end

   // automatic column strobe in external access, auto access sequencing
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cas_cnt  <= 4'h0;
         auto_cas <= 1'b0;
         acc_cnt  <= 4'h0;
         acc_col  <= 1'b0;
      end
      else
      begin
         if (!mode_ext_acc || row_col_select || col_strobe_input_n)
         begin
            auto_cas <= 1'b0;
            cas_cnt  <= 4'h0;
         end
         else if (prev_sel)
            cas_cnt <= CASU_CYC; // RULE22
         else if (cas_cnt > 4'h1)
            cas_cnt <= cas_cnt - 4'h1;
         else
            auto_cas <= 1'b1; // RULE22
         if (!mode_auto_acc || row_strobe_input_n || hidden_ok)
         begin
            acc_cnt <= 4'h0;
            acc_col <= 1'b0;
         end
         else if (acc_cnt < rah_cyc)
            acc_cnt <= acc_cnt + 4'h1; // RULE24
         else
            acc_col <= 1'b1; // RULE24
      end
   end

   // output steering
   always @*
   begin
      next_row_strobe_n = 4'hf;
      next_col_strobe_n = 1'b1; // RULE4
      next_dram_addr    = row_latch;
      if (ext_refresh)
      begin
         next_dram_addr    = ref_count;
         next_row_strobe_n = {4{row_strobe_input_n}}; // RULE6
      end
      else if (mode_auto_ref)
      begin
         if (fr_state != ST_IDLE)
            next_dram_addr = ref_count; // RULE11
      end
      else if (mode_ext_acc)
      begin
         next_dram_addr    = row_col_select ? row_latch : col_latch; // RULE18
         next_row_strobe_n = ~(bank_en & {4{~row_strobe_input_n}}); // RULE17
         if (!row_col_select)
            next_col_strobe_n = col_strobe_input_n | (~auto_cas & (prev_sel | (cas_cnt != 4'h0))); // RULE17 RULE22
      end
      else if (mode_auto_acc)
      begin
         // select and column pins ignored for timing here
         next_dram_addr    = acc_col ? col_latch : row_latch; // RULE25
         next_row_strobe_n = ~(bank_en & {4{~row_strobe_input_n}}); // RULE24
         next_col_strobe_n = ~acc_col; // RULE24
      end
      // early end leaves mode 1 at once, so row strobes must not follow the new mode
      if (fr_state == ST_LOW || fr_state == ST_REL)
         next_row_strobe_n = 4'h0; // RULE12 RULE14
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         row_strobe_n   <= 4'hf;
         col_strobe_n   <= 1'b1;
         write_enable_n <= 1'b1;
         dram_addr      <= 9'h000;
      end
      else
      begin
         row_strobe_n   <= next_row_strobe_n;
         col_strobe_n   <= next_col_strobe_n;
         write_enable_n <= write_input_n; // RULE17
         dram_addr      <= next_dram_addr;
      end
   end
endmodule // drfam_ctrl
`default_nettype wire

// file: dv/drfam_ctrl_checker.sv
// port assertions for the dram refresh and access controller
`timescale 1ns/1ps
`default_nettype none
module drfam_ctrl_checker
(
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // system side
   input wire logic       mode_bit_high,
   input wire logic       mode_bit_low,
   input wire logic       row_strobe_input_n,
   input wire logic       row_col_select,
   input wire logic       write_input_n,
   input wire logic       addr_strobe,
   input wire logic [8:0] row_addr_in,
   input wire logic       refresh_req_reset_pin_oe,
   // dram side
   input wire logic [3:0] row_strobe_n,
   input wire logic       col_strobe_n,
   input wire logic       write_enable_n,
   input wire logic [8:0] dram_addr
);
   wire [1:0] m;
   assign m = {mode_bit_high, mode_bit_low};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_we; m == 2'h2 && $past(m) == 2'h2 |-> write_enable_n == $past(write_input_n); endproperty
   property p_cas_hi;
      m == 2'h2 && $past(m) == 2'h2 && $past(row_col_select) |-> col_strobe_n;
   endproperty
   property p_row;
      (m == 2'h2 && row_col_select && addr_strobe && $stable(row_addr_in))[*3]
      |-> dram_addr == row_addr_in;
   endproperty
   property p_ref_cas; (m == 2'h0)[*2] |-> col_strobe_n; endproperty
   property p_ref_ras; (m == 2'h0)[*2] |-> row_strobe_n == {4{$past(row_strobe_input_n)}}; endproperty
   property p_cnt; (m == 2'h0)[*3] ##0 $changed(dram_addr) |-> dram_addr == $past(dram_addr) + 9'h1;
   endproperty
   property p_rel; m == 2'h1 && $fell(row_strobe_n[0]) |-> ##[0:2] !refresh_req_reset_pin_oe;
   endproperty
   property p_early; (m == 2'h1 && row_strobe_n == 4'h0) ##1 mode_bit_high |-> ##[1:8] &row_strobe_n;
   endproperty
   a_we: assert property (p_we) else $error("write enable not following");
   a_cas_hi: assert property (p_cas_hi) else $error("column strobe low on row select");
   a_row: assert property (p_row) else $error("row address not on outputs");
   a_ref_cas: assert property (p_ref_cas) else $error("column strobe in refresh");
   a_ref_ras: assert property (p_ref_ras) else $error("row strobes not following");
   a_cnt: assert property (p_cnt) else $error("refresh count step wrong");
   a_rel: assert property (p_rel) else $error("request not withdrawn");
   a_early: assert property (p_early) else $error("early end not released");
   c_forced: cover property (m == 2'h1 && row_strobe_n == 4'h0);
   c_req: cover property ($rose(refresh_req_reset_pin_oe));
   c_acc: cover property (m == 2'h2 && !col_strobe_n);
endmodule // drfam_ctrl_checker
bind drfam_ctrl drfam_ctrl_checker i_drfam_ctrl_checker (.*);
`default_nettype wire

// file: dv/drfam_sys_model.sv
// system side of the open-drain refresh request and clear pin
`timescale 1ns/1ps
`default_nettype none
module drfam_sys_model
(
   // device side of the pin
   input  wire logic pin_out,
   input  wire logic pin_oe,
   // clear request, open collector
   input  wire logic clear_req,
   // resolved level
   output wire logic pin_level
);
   // pulled up; an open collector never fights the device sinking it
   assign pin_level = ((pin_oe && !pin_out) || clear_req) ? 1'h0 : 1'h1;
endmodule // drfam_sys_model
`default_nettype wire

// file: dv/test_drfam_ctrl.sv
// self-checking bench for the dram refresh and access controller
`timescale 1ns/1ps
`default_nettype none
module test_drfam_ctrl;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, mh = 1'h0, ml = 1'h0, ras_in = 1'h1, cas_in = 1'h1;
   logic        rc = 1'h1, write_input = 1'h1, cs_n = 1'h0, ads = 1'h1, clr = 1'h0;
   logic        pin_lvl, pin_out, pin_oe, cas_n, we_n;
   logic [8:0]  row = 9'h15a, col = 9'h0a5, q;
   logic [3:0]  ras_n;
   int          n_fail = 0, checks = 0, k;
   always #2 pclk = ~pclk;
   drfam_ctrl i_drfam_ctrl
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mode_bit_high(mh), .mode_bit_low(ml), .row_strobe_input_n(ras_in),
      .col_strobe_input_n(cas_in), .row_col_select(rc), .write_input_n(write_input),
      .chip_select_n(cs_n), .row_addr_in(row), .col_addr_in(col), .addr_strobe(ads),
      .refresh_req_reset_pin_in(pin_lvl), .refresh_req_reset_pin_out(pin_out),
      .refresh_req_reset_pin_oe(pin_oe), .row_strobe_n(ras_n), .col_strobe_n(cas_n),
      .write_enable_n(we_n), .dram_addr(q)
   );
   drfam_sys_model i_drfam_sys_model
   (
      .pin_out(pin_out), .pin_oe(pin_oe), .clear_req(clr), .pin_level(pin_lvl)
   );
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // apb cycle; read data lands in rd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && t < 20)
      begin
         @(posedge pclk);
         t++;
      end
      if (t == 20)
      begin
         n_fail++;
         final_report;
      end
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // bounded wait: s=1 column strobe low, s=0 row strobes all high
   task automatic wt(input logic s);
      int t;
      for (t = 0; t < 30; t++)
      begin
         @(posedge pclk);
         if (s ? cas_n === 1'h0 : ras_n === 4'hf)
            return;
      end
      n_fail++;
      final_report;
   endtask
   task automatic pulse;
      @(posedge pclk);
      ras_in <= 1'h0;
      cyc(3);
      chk({ras_n, cas_n}, 5'h01);
      ras_in <= 1'h1;
      cyc(3);
   endtask
   // one sequence clock period, falling first
   task automatic fall;
      cas_in <= 1'h0;
      cyc(4);
      cas_in <= 1'h1;
      cyc(4);
   endtask
   initial
   begin
      cyc(2);
      presetn <= 1'h1;
      apb(1'h0, 12'h0, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, 12'h10, 32'h0);
      chk(rd, 32'h0);
      for (k = 0; k < 511; k++)
         pulse;
      apb(1'h0, 12'h4, 32'h0);
      chk(rd[8:0], 9'h1ff);
      pulse;
      apb(1'h0, 12'h4, 32'h0);
      chk(rd[8:0], 9'h0);
      ml <= 1'h1;
      pulse;
      clr <= 1'h1;
      cyc(3);
      clr <= 1'h0;
      apb(1'h0, 12'h4, 32'h0);
      chk(rd[8:0], 9'h0);
      // period already refreshed, so its fall must not request
      mh <= 1'h1;
      rc <= 1'h0;
      cyc(4);
      chk(pin_oe, 1'h0);
      rc <= 1'h1;
      cyc(4);
      rc <= 1'h0;
      cyc(4);
      chk(pin_lvl, 1'h0);
      mh <= 1'h0;
      cyc(1);
      for (k = 1; k <= 4; k++)
      begin
         fall;
         chk(ras_n, (k == 2 || k == 3) ? 4'h0 : 4'hf);
         if (k == 2)
            chk({pin_oe, cas_n, q}, {2'h1, 9'h0});
      end
      apb(1'h0, 12'h4, 32'h0);
      chk(rd[8:0], 9'h1);
      mh <= 1'h1;
      rc <= 1'h1;
      cyc(4);
      rc <= 1'h0;
      cyc(4);
      mh <= 1'h0;
      cyc(1);
      fall;
      fall;
      mh <= 1'h1;
      cyc(2);
      chk(ras_n, 4'h0);
      wt(1'h0);
      apb(1'h1, 12'h0, 32'h4);
      apb(1'h0, 12'h0, 32'h0);
      chk(rd, 32'h4);
      write_input <= 1'h0;
      cas_in <= 1'h0;
      ml <= 1'h0;
      rc <= 1'h1;
      cyc(4);
      chk({cas_n, we_n, q}, {2'h2, 9'h15a});
      ras_in <= 1'h0;
      cyc(4);
      chk(ras_n, 4'hb);
      rc <= 1'h0;
      cyc(2);
      chk(cas_n, 1'h1);
      cyc(3);
      chk({cas_n, q}, {1'h0, 9'h0a5});
      cas_in <= 1'h1;
      cyc(4);
      chk(cas_n, 1'h1);
      ras_in <= 1'h1;
      write_input <= 1'h1;
      ml <= 1'h1;
      cyc(4);
      ras_in <= 1'h0;
      wt(1'h1);
      chk({ras_n, q}, {4'hb, 9'h0a5});
      ras_in <= 1'h1;
      cyc(4);
      chk({ras_n, cas_n}, 5'h1f);
      final_report;
   end
endmodule // test_drfam_ctrl
`default_nettype wire
